//--- hdl/flash_self_program_control.sv
// flash program mode control register, unlock logic and internal processing status
`timescale 1ns/1ps
`include "flash_ctrl_consts.svh"
module flash_self_program_control
  import flash_ctrl_pkg::*;
#(
  parameter bit HAS_FLASH = 1'b1,
  parameter int unsigned AREA_COUNT = 4,
  parameter logic [31:0] AREA_SIZE = 32'h00080000
) (
  // system
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // cpu register bus
  input wire logic BUS_WR_I,
  input wire logic BUS_RD_I,
  input wire logic [31:0] BUS_ADDR_I,
  input wire logic [7:0] BUS_WDATA_I,
  input wire logic [7:0] BUS_BMASK_I,
  output logic [7:0] BUS_RDATA_O,
  // pins and device status
  input wire logic VPP_HIGH_I,
  input wire logic PROGRAMMER_MODE_I,
  input wire logic NMI_I,
  // internal processing call
  input wire logic CALL_I,
  input wire logic [7:0] FUNC_NUM_I,
  input wire logic [31:0] OPTION_ARG_I,
  input wire logic [15:0] TIMING_ARG_I,
  input wire logic OVER_ERASE_I,
  input wire logic UNDER_ERASE_I,
  output logic [31:0] RETURN_VALUE_O,
  output logic [15:0] TIMER_LOAD_O,
  output logic NMI_FLAG_SET_O,
  // flash control
  output logic SELF_PROG_ACTIVE_O,
  output logic FLASH_WRITE_EN_O,
  output logic FLASH_ACCESS_HOLD_O
);
  localparam int unsigned SETUP_CYCLES = (`SETUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  function automatic logic [31:0] area_start(input logic [31:0] n);
    area_start = n * AREA_SIZE;
  endfunction

  bus_req_t req;
  assign req = '{wr: BUS_WR_I, rd: BUS_RD_I, addr: BUS_ADDR_I, wdata: BUS_WDATA_I, bmask: BUS_BMASK_I};

  ////////////////////////////////////////////////////////////////////////
  // mode control register and unlock
  logic wr_dis_ff, nxt_wr_dis;
  logic self_sel_ff, nxt_self_sel;
  logic unlock_ff, nxt_unlock;
  logic prot_err_ff, nxt_prot_err;
  logic [7:0] mode_rd;
  logic [7:0] merged;
  logic vpp_bit;

  assign vpp_bit = HAS_FLASH & VPP_HIGH_I;
  always_comb begin
    mode_rd = 8'h00;
    mode_rd[`BIT_WR_DISABLE] = wr_dis_ff;
    mode_rd[`BIT_VPP_OK] = vpp_bit;
    mode_rd[`BIT_SELF_PROG] = self_sel_ff;
  end
  // bit writes merge under the mask so untouched bits keep their value
  assign merged = (mode_rd & ~req.bmask) | (req.wdata & req.bmask);

  always_comb begin
    nxt_wr_dis = wr_dis_ff;
    nxt_self_sel = self_sel_ff;
    nxt_unlock = unlock_ff;
    nxt_prot_err = prot_err_ff;
    if (req.wr) begin
      nxt_unlock = (req.addr == `PROT_CMD_ADDR);
      if (req.addr == `MODE_CTRL_ADDR) begin
        if (unlock_ff && HAS_FLASH) begin
          nxt_wr_dis = merged[`BIT_WR_DISABLE];
          nxt_self_sel = merged[`BIT_SELF_PROG];
        end else if (!unlock_ff) begin
          nxt_prot_err = 1'b1;
        end
      end
      if (req.addr == `PROT_STAT_ADDR && !req.wdata[`BIT_PROT_ERR]) begin
        nxt_prot_err = 1'b0;
      end
      // a fresh failure in the clearing cycle still wins
      if (req.addr == `MODE_CTRL_ADDR && !unlock_ff) begin
        nxt_prot_err = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      // reset value follows flash presence: 08h/0ch with flash, 00h without
      wr_dis_ff <= HAS_FLASH;
      self_sel_ff <= 1'b0;
      unlock_ff <= 1'b0;
      prot_err_ff <= 1'b0;
    end else begin
      unlock_ff <= nxt_unlock;
      prot_err_ff <= nxt_prot_err;
      self_sel_ff <= nxt_self_sel;
      wr_dis_ff <= nxt_wr_dis;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode tracking and setup hold-off
  prog_mode_t mode_ff, nxt_mode;
  logic self_eff;
  logic setup_start;
  logic setup_busy;

  assign self_eff = self_sel_ff & vpp_bit & ~PROGRAMMER_MODE_I;
  always_comb begin
    nxt_mode = mode_ff;
    setup_start = 1'b0;
    case (mode_ff)
      MODE_NORMAL: begin
        if (self_eff) nxt_mode = MODE_SELF;
      end
      MODE_SELF: begin
        if (!self_eff) begin
          nxt_mode = MODE_SETUP;
          setup_start = 1'b1;
        end
      end
      MODE_SETUP: begin
        if (self_eff) nxt_mode = MODE_SELF;
        else if (!setup_busy && !setup_start) nxt_mode = MODE_NORMAL;
      end
      default: nxt_mode = MODE_NORMAL;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mode_ff <= MODE_NORMAL;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  setup_timer #(
    .CYCLES(SETUP_CYCLES)
  ) u_setup (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .start_i(setup_start),
    .busy_o(setup_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // internal processing results
  logic [31:0] ret_ff, nxt_ret;
  logic [15:0] tload_ff, nxt_tload;
  logic nmi_ff, nxt_nmi;
  logic [7:0] rdata_ff, nxt_rdata;
  logic active_ff, wen_ff, hold_ff;
  logic nxt_active, nxt_wen, nxt_hold;

  always_comb begin
    nxt_active = (nxt_mode == MODE_SELF);
    nxt_wen = self_eff & ~wr_dis_ff;
    nxt_hold = (nxt_mode == MODE_SETUP);
    nxt_ret = ret_ff;
    nxt_tload = tload_ff;
    nxt_nmi = 1'b0;
    if (mode_ff == MODE_SELF && NMI_I) nxt_nmi = 1'b1;
    if (CALL_I && mode_ff == MODE_SELF) begin
      nxt_tload = TIMING_ARG_I - 16'h0001;
      nxt_ret = `SUCCESS_CODE;
      if (FUNC_NUM_I == 8'h00) begin
        // option is not range-checked; beyond the areas this is just arithmetic
        nxt_ret = area_start(OPTION_ARG_I);
      end else if (wr_dis_ff) begin
        nxt_ret = `ERR_WRITE_BLOCKED;
      end else begin
        if (OVER_ERASE_I) nxt_ret = nxt_ret | `ERR_OVER_ERASE;
        if (UNDER_ERASE_I) nxt_ret = nxt_ret | `ERR_UNDER_ERASE;
      end
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;
    if (req.rd && req.addr == `MODE_CTRL_ADDR) nxt_rdata = mode_rd;
    if (req.rd && req.addr == `PROT_STAT_ADDR) nxt_rdata = {7'h00, prot_err_ff};
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ret_ff <= `SUCCESS_CODE;
      tload_ff <= 16'h0000;
      nmi_ff <= 1'b0;
      rdata_ff <= 8'h00;
      active_ff <= 1'b0;
      wen_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      ret_ff <= nxt_ret;
      tload_ff <= nxt_tload;
      nmi_ff <= nxt_nmi;
      rdata_ff <= nxt_rdata;
      active_ff <= nxt_active;
      wen_ff <= nxt_wen;
      hold_ff <= nxt_hold;
    end
  end

  assign BUS_RDATA_O = rdata_ff;
  assign RETURN_VALUE_O = ret_ff;
  assign TIMER_LOAD_O = tload_ff;
  assign NMI_FLAG_SET_O = nmi_ff;
  assign SELF_PROG_ACTIVE_O = active_ff;
  assign FLASH_WRITE_EN_O = wen_ff;
  assign FLASH_ACCESS_HOLD_O = hold_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks
  locked_write_err_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (req.wr && req.addr == `MODE_CTRL_ADDR && !unlock_ff) |=> prot_err_ff && $stable(self_sel_ff))
    else $error("locked write not flagged");
  unlock_consumed_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (req.wr && req.addr != `PROT_CMD_ADDR) |=> !unlock_ff)
    else $error("unlock survived a write");
  write_block_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    wr_dis_ff |=> !FLASH_WRITE_EN_O)
    else $error("write enabled while disabled");
  vpp_gate_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (!VPP_HIGH_I || PROGRAMMER_MODE_I) |=> !FLASH_WRITE_EN_O)
    else $error("write enabled without voltage");
  timer_load_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CALL_I && mode_ff == MODE_SELF) |=> TIMER_LOAD_O == $past(TIMING_ARG_I) - 16'h0001)
    else $error("timer load off");
  both_errors_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CALL_I && mode_ff == MODE_SELF && FUNC_NUM_I != 8'h00 && !wr_dis_ff && OVER_ERASE_I && UNDER_ERASE_I)
    |=> RETURN_VALUE_O == (`ERR_OVER_ERASE | `ERR_UNDER_ERASE))
    else $error("errors not combined");
  setup_hold_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (mode_ff == MODE_SELF && !self_eff) |=> ##1 FLASH_ACCESS_HOLD_O [*8])
    else $error("setup hold too short");
  read_back_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (req.rd && req.addr == `MODE_CTRL_ADDR) |=> BUS_RDATA_O[`BIT_VPP_OK] == $past(vpp_bit))
    else $error("status bit read wrong");
endmodule

//--- pkg/flash_ctrl_consts.svh
// address map, field positions, reset values and timing for the flash mode control block
`ifndef FLASH_CTRL_CONSTS_SVH
`define FLASH_CTRL_CONSTS_SVH
`define MODE_CTRL_ADDR 32'hfffff8d4
`define PROT_CMD_ADDR 32'hfffff8d0
`define PROT_STAT_ADDR 32'hfffff8d8
`define MODE_RST_NOVPP 8'h08
`define MODE_RST_VPP 8'h0c
`define MODE_RST_NOFLASH 8'h00
`define BIT_WR_DISABLE 3
`define BIT_VPP_OK 2
`define BIT_SELF_PROG 1
`define BIT_PROT_ERR 0
`define BIT_NMI_FLAG 7
`define SETUP_TIME_NS 100000
`define CLK_PERIOD_NS 10
`define SUCCESS_CODE 32'h00000000
`define ERR_OVER_ERASE 32'h00000001
`define ERR_UNDER_ERASE 32'h00000002
`define ERR_WRITE_BLOCKED 32'h00000004
`endif

//--- pkg/flash_ctrl_pkg.sv
// types shared by the flash self-program control block
package flash_ctrl_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [7:0] wdata;
    logic [7:0] bmask;
  } bus_req_t;
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SELF,
    MODE_SETUP
  } prog_mode_t;
endpackage

//--- hdl/setup_timer.sv
// countdown timer that holds off flash access after leaving self-program mode
`timescale 1ns/1ps
module setup_timer #(
  parameter int unsigned CYCLES = 10000
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  output logic busy_o
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (start_i) begin
      nxt_cnt = 16'(CYCLES);
    end else if (cnt_ff != 16'h0000) begin
      nxt_cnt = cnt_ff - 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy_o = (cnt_ff != 16'h0000);
endmodule

//--- verif/host_cpu_model.sv
// host cpu model: drives the register bus just after falling edges
`timescale 1ns/1ps
`include "flash_ctrl_consts.svh"
module host_cpu_model
  import flash_ctrl_pkg::*;
(
  // system
  input wire logic clk_i,
  // register bus
  output bus_req_t req_o,
  input wire logic [7:0] rdata_i
);
  initial req_o = '0;
  // released lines show the inverse of the last drive; after a read, data flips back to its stale value
  task automatic idle();
    req_o = '{1'b0, 1'b0, ~req_o.addr, ~req_o.wdata, ~req_o.bmask};
    @(negedge clk_i);
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [7:0] m);
    req_o = '{1'b1, 1'b0, a, d, m};
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [31:0] a, output logic [7:0] d);
    req_o = '{1'b0, 1'b1, a, ~req_o.wdata, 8'h00};
    @(negedge clk_i);
    d = rdata_i;
    idle();
  endtask
  // one data word for command and target; reserved bits kept at zero
  task automatic unlock(input logic [7:0] d, input logic [7:0] m);
    wr(`PROT_CMD_ADDR, d & 8'h0e, 8'hff);
    wr(`MODE_CTRL_ADDR, d & 8'h0e, m);
    idle();
    repeat (4) @(negedge clk_i);
  endtask
endmodule

//--- verif/flash_self_program_control_tb.sv
// self-checking bench for the flash self-program control block
`timescale 1ns/1ps
`include "flash_ctrl_consts.svh"
module flash_self_program_control_tb;
  import flash_ctrl_pkg::*;
  localparam logic [31:0] AREA_SZ = 32'h00080000;
  // continuous word-write source: word aligned, in ram outside flash
  localparam logic [31:0] WR_SRC = 32'h03ffe100;
  logic clk, resetn, vpp, prog, nmi, call, over, under, nmi_set, self_act, wen, hold;
  logic [7:0] func, rdat;
  logic [31:0] opt, ret;
  logic [15:0] tmg, tload;
  bus_req_t req;
  int failures = 0;
  int total_checks = 0;
  int seed = 32'h08c5;
  int n;
  logic [15:0] t;
  logic [31:0] o;
  logic ov, un;
  host_cpu_model i_host_cpu_model (.clk_i(clk), .req_o(req), .rdata_i(rdat));
  flash_self_program_control #(.HAS_FLASH(1'b1), .AREA_COUNT(4), .AREA_SIZE(AREA_SZ)) i_flash_self_program_control (
    .CLK_I(clk), .RESETN_I(resetn), .BUS_WR_I(req.wr), .BUS_RD_I(req.rd), .BUS_ADDR_I(req.addr),
    .BUS_WDATA_I(req.wdata), .BUS_BMASK_I(req.bmask), .BUS_RDATA_O(rdat), .VPP_HIGH_I(vpp),
    .PROGRAMMER_MODE_I(prog), .NMI_I(nmi), .CALL_I(call), .FUNC_NUM_I(func), .OPTION_ARG_I(opt),
    .TIMING_ARG_I(tmg), .OVER_ERASE_I(over), .UNDER_ERASE_I(under), .RETURN_VALUE_O(ret),
    .TIMER_LOAD_O(tload), .NMI_FLAG_SET_O(nmi_set), .SELF_PROG_ACTIVE_O(self_act),
    .FLASH_WRITE_EN_O(wen), .FLASH_ACCESS_HOLD_O(hold));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdck(input string nm, input logic [31:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host_cpu_model.rd(a, d);
    chk(nm, {24'h0, e}, {24'h0, d});
  endtask
  function automatic logic [31:0] exp_area(input logic [31:0] a);
    exp_area = a * AREA_SZ;
  endfunction
  function automatic logic [31:0] exp_erase(input logic ovr, input logic und);
    exp_erase = `SUCCESS_CODE;
    if (ovr) exp_erase = exp_erase | `ERR_OVER_ERASE;
    if (und) exp_erase = exp_erase | `ERR_UNDER_ERASE;
  endfunction
  // call stays high between back-to-back calls; caller lowers it
  task automatic docall(input logic [7:0] f, input logic [31:0] op, input logic [15:0] tm, input logic ov_i,
                        input logic un_i);
    call = 1'b1;
    func = f;
    opt = op;
    tmg = tm;
    over = ov_i;
    under = un_i;
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("[FAIL] run time expected end seen hang");
    summarize();
  end
  initial begin
    {resetn, vpp, prog, nmi, call, over, under} = 7'h00;
    func = 8'h00;
    opt = 32'h0;
    tmg = 16'h0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    rdck("mode_rst", `MODE_CTRL_ADDR, `MODE_RST_NOVPP);
    rdck("unmapped", 32'hfffff8dc, 8'h00);
    i_host_cpu_model.unlock(8'h02, 8'hff);
    chk("self_novpp", 0, {31'h0, self_act});
    i_host_cpu_model.unlock(8'h08, 8'hff);
    vpp = 1'b1;
    @(negedge clk);
    rdck("mode_vpp", `MODE_CTRL_ADDR, `MODE_RST_VPP);
    i_host_cpu_model.wr(`MODE_CTRL_ADDR, 8'h02, 8'hff);
    i_host_cpu_model.idle();
    rdck("err_set", `PROT_STAT_ADDR, 8'h01);
    i_host_cpu_model.wr(`PROT_CMD_ADDR, 8'h02, 8'hff);
    i_host_cpu_model.wr(`PROT_STAT_ADDR, 8'h00, 8'hff);
    i_host_cpu_model.wr(`MODE_CTRL_ADDR, 8'h02, 8'hff);
    i_host_cpu_model.idle();
    rdck("cancel", `MODE_CTRL_ADDR, 8'h0c);
    rdck("cancel_err", `PROT_STAT_ADDR, 8'h01);
    prog = 1'b1;
    i_host_cpu_model.unlock(8'h02, 8'hff);
    chk("self_prog", 0, {31'h0, self_act});
    i_host_cpu_model.unlock(8'h08, 8'hff);
    prog = 1'b0;
    i_host_cpu_model.unlock(8'h02, 8'hff);
    chk("self_on", 1, {31'h0, self_act});
    chk("wen_on", 1, {31'h0, wen});
    rdck("mode_self", `MODE_CTRL_ADDR, 8'h06);
    for (int k = 0; k < 20; k++) begin
      t = (k == 0) ? 16'h0001 : 16'(($random(seed) & 16'h7fff) + 1);
      o = (k == 0) ? 32'h0 : 32'($unsigned($random(seed)) % 4);
      ov = 1'($random(seed));
      un = (k == 1) ? 1'b1 : 1'($random(seed));
      ov = (k == 1) ? 1'b1 : ov;
      docall(8'h00, o, t, 1'b0, 1'b0);
      chk("area_start", exp_area(o), ret);
      chk("timer_load", {16'h0, t - 16'h1}, {16'h0, tload});
      docall(8'h01, 32'h0, t, ov, un);
      chk("erase_ret", exp_erase(ov, un), ret);
    end
    docall(8'h10, WR_SRC, t, 1'b0, 1'b0);
    chk("word_write", `SUCCESS_CODE, ret);
    call = 1'b0;
    i_host_cpu_model.unlock(8'h08, 8'h08);
    chk("wen_dis", 0, {31'h0, wen});
    rdck("mode_dis", `MODE_CTRL_ADDR, 8'h0e);
    t = 16'h0003;
    docall(8'h01, 32'h0, t, 1'b1, 1'b1);
    call = 1'b0;
    chk("blocked_ret", `ERR_WRITE_BLOCKED, ret);
    nmi = 1'b1;
    @(negedge clk);
    chk("nmi_flag", 1, {31'h0, nmi_set});
    nmi = 1'b0;
    i_host_cpu_model.unlock(8'h08, 8'hff);
    chk("self_off", 0, {31'h0, self_act});
    chk("hold_on", 1, {31'h0, hold});
    n = 0;
    while (hold === 1'b1 && n < 12000) begin
      @(negedge clk);
      n++;
    end
    chk("hold_len", 1, {31'h0, n >= 9990 && n <= 10000});
    docall(8'h00, 32'h2, 16'h5, 1'b0, 1'b0);
    call = 1'b0;
    chk("call_ignored", {16'h0, t - 16'h1}, {16'h0, tload});
    chk("ret_kept", `ERR_WRITE_BLOCKED, ret);
    nmi = 1'b1;
    @(negedge clk);
    chk("nmi_outside", 0, {31'h0, nmi_set});
    nmi = 1'b0;
    // second reset with the programming voltage up
    resetn = 1'b0;
    @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    rdck("mode_rst_vpp", `MODE_CTRL_ADDR, `MODE_RST_VPP);
    rdck("err_rst", `PROT_STAT_ADDR, 8'h00);
    chk("hold_rst", 0, {31'h0, hold});
    summarize();
  end
endmodule
